// ### design/usb_dma_pkg.sv
// Purpose: shared constants, states and carriers of the endpoint transmit DMA engine
// Assumes: 32-bit APB register bus, one 200 MHz clock
// Notes: descriptor fields and register offsets live here only
package usb_dma_pkg;
  // ----------------------------------------------------------------
  // channel layout
  // ----------------------------------------------------------------
  localparam int NUM_CH = 4; // transmit and receive channels each
  localparam logic [2:0] EP_BASE = 3'h1; // channel n serves endpoint n + 1
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_TX_HEAD = 8'h00; // head descriptor pointer, one word per channel
  localparam logic [7:0] OFF_TX_CUR = 8'h10; // current descriptor pointer, read only
  localparam logic [7:0] OFF_MODE = 8'h20; // bits 3:0 encapsulation mode per tx channel
  localparam logic [7:0] OFF_STATUS = 8'h24; // busy, active channel, armed channels
  localparam logic [7:0] OFF_RX_HEAD = 8'h30; // receive head pointers, one word per channel
  localparam logic [7:0] MODE_RST = 8'h00; // all channels transparent after reset
  // ----------------------------------------------------------------
  // descriptor layout
  // ----------------------------------------------------------------
  localparam logic [4:0] DESC_BEATS = 5'h04; // four words, sixteen bytes
  localparam logic [31:0] W3_BYTE_OFS = 32'h0000_000c; // byte offset of word 3
  localparam int BIT_PSTART = 31;
  localparam int BIT_PEND = 30;
  localparam int BIT_OWN = 29;
  localparam int BIT_QEND = 28;
  localparam int BIT_ZERO = 23;
  localparam logic [6:0] BURST_BYTES = 7'h40; // at most 64 bytes per burst
  localparam int LINE_WORDS = 16;
  // ----------------------------------------------------------------
  // engine states, gray coded in declaration order
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_LOAD = 4'h1, ST_DESC = 4'h3, ST_CHECK = 4'h2,
    ST_DREQ = 4'h6, ST_DRX = 4'h7, ST_DOUT = 4'h5, ST_ZLP = 4'h4,
    ST_DONE = 4'hc, ST_WB_OWN = 4'hd, ST_WB_QEND = 4'hf, ST_SAVE = 4'he
  } eng_state_e;
  // memory request: held until mem_gnt; reads return beats on mem_rvalid
  typedef struct packed {
    logic valid;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [4:0] beats;
  } mem_req_s;
  // byte towards an endpoint fifo
  typedef struct packed {
    logic valid;
    logic last;
    logic zlp;
    logic [2:0] ep;
    logic [7:0] data;
  } fifo_beat_s;
endpackage : usb_dma_pkg

// ### design/usb_tx_dma.sv
// Purpose: descriptor-walking transmit DMA feeding the endpoint fifos
// Assumes: memory answers a read request with its beats in address order
// Notes: one shared engine serves the four transmit channels, lowest armed channel first
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module usb_tx_dma
  import usb_dma_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output mem_req_s mem_req,
  input wire logic mem_gnt,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  output fifo_beat_s fifo_out,
  input wire logic [NUM_CH-1:0] fifo_ready
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  eng_state_e state_ff; // engine state
  logic [1:0] chan_ff; // channel being served
  logic [31:0] dw_ff [DESC_BEATS]; // fetched descriptor words
  logic [31:0] sop_ptr_ff; // start descriptor of the current packet
  logic [31:0] sop_w3_ff; // its word 3 as fetched
  logic [31:0] buf_ptr_ff; // next byte address in the buffer
  logic [15:0] buf_left_ff; // bytes still to move from this buffer
  logic [15:0] pkt_left_ff; // bytes still allowed in this packet
  logic [4:0] beat_ff; // beat counter of a read burst
  logic [4:0] words_ff; // words in the current data burst
  logic [6:0] line_left_ff; // bytes of the burst not yet sent
  logic [5:0] byte_idx_ff; // byte position inside the line
  logic [31:0] line_ff [LINE_WORDS]; // one burst of buffer data
  logic [31:0] head_ff [NUM_CH]; // software head pointers
  logic [31:0] cur_ff [NUM_CH]; // saved current descriptor pointers
  logic [31:0] rx_head_ff [NUM_CH]; // receive channel head pointers
  logic [NUM_CH-1:0] armed_ff; // channel has a queue to walk
  logic [7:0] mode_ff; // per channel mode select
  logic [31:0] rdata_mux; // read data before the flop
  logic map_hit; // address decodes to a register
  logic apb_wr; // register write in the access phase
  logic issue; // a byte leaves towards the fifo this cycle
  logic zlp_issue; // an empty packet marker leaves this cycle
  logic [1:0] pick; // lowest armed channel
  logic [1:0] lane; // byte lane of the buffer pointer
  logic [6:0] room; // bytes left in a 64 byte burst window
  logic [6:0] take; // bytes that this burst will carry
  logic [7:0] span; // lane plus take plus rounding
  logic pkt_end; // current descriptor closes its packet
  logic [31:0] next_ptr; // word 0 of the current descriptor
  logic [15:0] eff_pkt; // packet budget seen by this buffer
  logic [15:0] eff_len; // bytes this buffer contributes
  logic [7:0] cur_byte; // byte selected from the line
  // ----------------------------------------------------------------
  // apb slave: zero wait states, error on unmapped offsets
  // ----------------------------------------------------------------
  assign apb_wr = psel & penable & pwrite & pready;
  // decode and read mux
  always_comb begin
    map_hit = 1'b1;
    rdata_mux = 32'h0000_0000;
    if (paddr[1:0] != 2'h0) begin
      map_hit = 1'b0;
    end else if (paddr[7:4] == OFF_TX_HEAD[7:4]) begin
      rdata_mux = head_ff[paddr[3:2]];
    end else if (paddr[7:4] == OFF_TX_CUR[7:4]) begin
      rdata_mux = cur_ff[paddr[3:2]];
    end else if (paddr[7:4] == OFF_RX_HEAD[7:4]) begin
      rdata_mux = rx_head_ff[paddr[3:2]];
    end else if (paddr == OFF_MODE) begin
      rdata_mux = {24'h00_0000, mode_ff};
    end else if (paddr == OFF_STATUS) begin
      rdata_mux = {16'h0000, state_ff != ST_IDLE, 5'h00, chan_ff, 4'h0, armed_ff};
    end else begin
      map_hit = 1'b0;
    end
  end
  // answer is prepared in the setup cycle so the access phase ends at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~map_hit;
      prdata <= (psel & ~penable & ~pwrite) ? rdata_mux : 32'h0000_0000;
    end
  end
  // mode register: a set bit selects encapsulation for that channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= MODE_RST;
    end else if (apb_wr && !pslverr && paddr == OFF_MODE) begin
      mode_ff <= pwdata[7:0];
    end
  end
  // ----------------------------------------------------------------
  // per channel queue state
  // ----------------------------------------------------------------
  // four channel slots each way
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        head_ff[i] <= 32'h0000_0000;
        cur_ff[i] <= 32'h0000_0000;
        rx_head_ff[i] <= 32'h0000_0000;
        armed_ff[i] <= 1'b0;
      end else if (apb_wr && !pslverr && paddr == (OFF_TX_HEAD + 8'(4 * i))) begin
        // a new head restarts the queue; it wins over a save in the same cycle
        head_ff[i] <= pwdata;
        cur_ff[i] <= pwdata;
        armed_ff[i] <= pwdata != 32'h0000_0000;
      end else if (apb_wr && !pslverr && paddr == (OFF_RX_HEAD + 8'(4 * i))) begin
        rx_head_ff[i] <= pwdata;
      end else if (state_ff == ST_SAVE && chan_ff == 2'(i)) begin
        // zero next pointer parks the channel
        cur_ff[i] <= next_ptr;
        armed_ff[i] <= next_ptr != 32'h0000_0000;
      end else if (state_ff == ST_CHECK && chan_ff == 2'(i) && dw_ff[3][BIT_PSTART] && !dw_ff[3][BIT_OWN]) begin
        // packet not owned by the engine: stop
        armed_ff[i] <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // burst sizing and descriptor fields
  // ----------------------------------------------------------------
  always_comb begin
    pick = 2'h0;
    for (int k = NUM_CH - 1; k >= 0; k--) begin
      if (armed_ff[k]) begin
        pick = 2'(k);
      end
    end
  end
  // word 0 links to the next descriptor
  assign next_ptr = dw_ff[0];
  // packet delimited by the end flag
  assign pkt_end = dw_ff[3][BIT_PEND];
  assign lane = buf_ptr_ff[1:0];
  // burst window never passes 64 bytes
  assign room = BURST_BYTES - {5'h00, lane};
  assign take = (buf_left_ff < {9'h000, room}) ? buf_left_ff[6:0] : room;
  assign span = {6'h00, lane} + {1'b0, take} + 8'h03;
  // buffer clipped to the packet budget
  assign eff_pkt = dw_ff[3][BIT_PSTART] ? dw_ff[3][15:0] : pkt_left_ff;
  // buffer length counts valid bytes only
  assign eff_len = (dw_ff[2][15:0] < eff_pkt) ? dw_ff[2][15:0] : eff_pkt;
  assign cur_byte = line_ff[byte_idx_ff[5:2]][8 * byte_idx_ff[1:0] +: 8];
  assign issue = state_ff == ST_DOUT && (!fifo_out.valid || fifo_ready[chan_ff]);
  assign zlp_issue = state_ff == ST_ZLP && (!fifo_out.valid || fifo_ready[chan_ff]);
  // ----------------------------------------------------------------
  // engine sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      chan_ff <= 2'h0;
      beat_ff <= 5'h00;
    end else begin
      case (state_ff)
        // pick the lowest armed channel
        ST_IDLE: begin
          if (armed_ff != '0) begin
            chan_ff <= pick;
            state_ff <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          beat_ff <= 5'h00;
          state_ff <= ST_DESC;
        end
        ST_DESC: begin
          if (mem_rvalid) begin
            beat_ff <= beat_ff + 5'h01;
            if (beat_ff == DESC_BEATS - 5'h01) begin
              state_ff <= ST_CHECK;
            end
          end
        end
        // zero-byte descriptor skips the data fetch
        ST_CHECK: begin
          if (dw_ff[3][BIT_PSTART] && !dw_ff[3][BIT_OWN]) begin
            state_ff <= ST_IDLE;
          end else if (dw_ff[3][BIT_ZERO]) begin
            state_ff <= ST_ZLP;
          end else begin
            state_ff <= ST_DREQ;
          end
        end
        ST_DREQ: begin
          beat_ff <= 5'h00;
          state_ff <= (buf_left_ff == 16'h0000) ? ST_DONE : ST_DRX;
        end
        ST_DRX: begin
          if (mem_rvalid) begin
            beat_ff <= beat_ff + 5'h01;
            if (beat_ff == words_ff - 5'h01) begin
              state_ff <= ST_DOUT;
            end
          end
        end
        ST_DOUT: begin
          if (issue && line_left_ff == 7'h01) begin
            state_ff <= ST_DREQ;
          end
        end
        ST_ZLP: begin
          if (zlp_issue) begin
            state_ff <= ST_DONE;
          end
        end
        // stay on the channel until the packet closes
        ST_DONE: begin
          state_ff <= pkt_end ? ST_WB_OWN : ST_SAVE;
        end
        ST_WB_OWN: begin
          if (mem_gnt) begin
            state_ff <= (next_ptr == 32'h0000_0000) ? ST_WB_QEND : ST_SAVE;
          end
        end
        ST_WB_QEND: begin
          if (mem_gnt) begin
            state_ff <= ST_SAVE;
          end
        end
        ST_SAVE: begin
          state_ff <= (!pkt_end && next_ptr != 32'h0000_0000) ? ST_LOAD : ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end
  // descriptor words and line buffer capture
  always_ff @(posedge pclk) begin
    if (state_ff == ST_DESC && mem_rvalid) begin
      dw_ff[beat_ff[1:0]] <= mem_rdata;
    end
    if (state_ff == ST_DRX && mem_rvalid) begin
      line_ff[beat_ff[3:0]] <= mem_rdata;
    end
  end
  // buffer and packet counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sop_ptr_ff <= 32'h0000_0000;
      sop_w3_ff <= 32'h0000_0000;
      buf_ptr_ff <= 32'h0000_0000;
      buf_left_ff <= 16'h0000;
      pkt_left_ff <= 16'h0000;
      words_ff <= 5'h00;
      line_left_ff <= 7'h00;
      byte_idx_ff <= 6'h00;
    end else if (state_ff == ST_CHECK) begin
      if (dw_ff[3][BIT_PSTART]) begin
        sop_ptr_ff <= cur_ff[chan_ff];
        sop_w3_ff <= dw_ff[3];
      end
      // data starts past the skipped bytes
      buf_ptr_ff <= dw_ff[1] + (dw_ff[3][BIT_PSTART] ? {16'h0000, dw_ff[2][31:16]} : 32'h0000_0000);
      buf_left_ff <= dw_ff[3][BIT_ZERO] ? 16'h0000 : eff_len;
      pkt_left_ff <= dw_ff[3][BIT_ZERO] ? eff_pkt : eff_pkt - eff_len;
    end else if (state_ff == ST_DREQ) begin
      words_ff <= span[6:2];
      line_left_ff <= take;
      byte_idx_ff <= {4'h0, lane};
    end else if (issue) begin
      buf_ptr_ff <= buf_ptr_ff + 32'h0000_0001;
      buf_left_ff <= buf_left_ff - 16'h0001;
      line_left_ff <= line_left_ff - 7'h01;
      byte_idx_ff <= byte_idx_ff + 6'h01;
    end
  end
  // ----------------------------------------------------------------
  // memory request port
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req <= '0;
    end else if (mem_req.valid && !mem_gnt) begin
      mem_req <= mem_req; // held until granted
    end else if (state_ff == ST_LOAD) begin
      mem_req <= '{valid: 1'b1, we: 1'b0, addr: {cur_ff[chan_ff][31:2], 2'h0}, wdata: 32'h0000_0000, beats: DESC_BEATS};
    end else if (state_ff == ST_DREQ && buf_left_ff != 16'h0000) begin
      mem_req <= '{valid: 1'b1, we: 1'b0, addr: {buf_ptr_ff[31:2], 2'h0}, wdata: 32'h0000_0000, beats: span[6:2]};
    end else if (state_ff == ST_DONE && pkt_end) begin
      // hand the packet back to software
      mem_req <= '{valid: 1'b1, we: 1'b1, addr: sop_ptr_ff + W3_BYTE_OFS,
                   wdata: sop_w3_ff & ~(32'h1 << BIT_OWN), beats: 5'h01};
    end else if (state_ff == ST_WB_OWN && mem_gnt && next_ptr == 32'h0000_0000) begin
      // mark the last end descriptor; keep ownership cleared if it is the start too
      mem_req <= '{valid: 1'b1, we: 1'b1, addr: cur_ff[chan_ff] + W3_BYTE_OFS,
                   wdata: (cur_ff[chan_ff] == sop_ptr_ff ? dw_ff[3] & ~(32'h1 << BIT_OWN) : dw_ff[3])
                          | (32'h1 << BIT_QEND), beats: 5'h01};
    end else begin
      mem_req <= '0;
    end
  end
  // ----------------------------------------------------------------
  // endpoint fifo output
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_out <= '0;
    end else if (issue || zlp_issue) begin
      fifo_out.valid <= 1'b1;
      fifo_out.zlp <= zlp_issue;
      // endpoint is channel plus one, never zero
      fifo_out.ep <= {1'b0, chan_ff} + EP_BASE;
      fifo_out.data <= zlp_issue ? 8'h00 : cur_byte;
      // encapsulation mode marks only the end of the whole chain
      fifo_out.last <= (zlp_issue || buf_left_ff == 16'h0001) && (pkt_end || pkt_left_ff == 16'h0000)
                       && (!mode_ff[chan_ff] || next_ptr == 32'h0000_0000);
    end else if (fifo_ready[chan_ff]) begin
      fifo_out.valid <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_BURST_MAX: assert property (@(posedge pclk) disable iff (!presetn)
    mem_req.valid && !mem_req.we |-> mem_req.beats <= 5'h10 && mem_req.beats != 5'h00)
    else $error("read burst longer than 64 bytes");
  AST_EP_MAP: assert property (@(posedge pclk) disable iff (!presetn)
    issue |=> fifo_out.ep == {1'b0, $past(chan_ff)} + 3'h1)
    else $error("byte sent to the wrong endpoint");
  AST_NO_EP0: assert property (@(posedge pclk) disable iff (!presetn)
    fifo_out.valid |-> fifo_out.ep != 3'h0)
    else $error("traffic on endpoint zero");
  AST_DESC_FETCH: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_LOAD |=> mem_req.valid && mem_req.beats == 5'h04 && mem_req.addr[1:0] == 2'h0)
    else $error("descriptor fetch not issued after parameter load");
  AST_OWN_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_WB_OWN && mem_req.valid |-> mem_req.we && !mem_req.wdata[29]
    && mem_req.addr == sop_ptr_ff + 32'h0000_000c)
    else $error("ownership not cleared in start descriptor");
  AST_QEND_SET: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_WB_QEND && mem_req.valid |-> mem_req.wdata[28] && mem_req.wdata[30])
    else $error("queue end flag missing");
  AST_ZLP_NOFETCH: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_CHECK && dw_ff[3][23] && !(dw_ff[3][31] && !dw_ff[3][29])
    |=> state_ff == ST_ZLP ##0 !mem_req.valid)
    else $error("zero-byte descriptor fetched data");
  AST_TRUNC: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_CHECK && !dw_ff[3][23] |=> buf_left_ff <= $past(eff_pkt) && buf_left_ff <= $past(dw_ff[2][15:0]))
    else $error("buffer exceeds packet budget");
  AST_OFFSET: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_CHECK && dw_ff[3][31] |=> buf_ptr_ff == $past(dw_ff[1]) + {16'h0000, $past(dw_ff[2][31:16])})
    else $error("leading byte offset not applied");
  AST_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_SAVE && next_ptr == 32'h0000_0000 && !apb_wr |=> !armed_ff[$past(chan_ff)])
    else $error("channel kept running past a zero next pointer");
endmodule : usb_tx_dma

// ### verification/sys_mem.sv
// Purpose: behavioural system memory facing the dma request port
// Assumes: word storage indexed by address bits 9:2, preloaded by the bench
// Notes: grants only on every other cycle, so the engine sees stalls
`timescale 1ns/1ps
module sys_mem
  import usb_dma_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input mem_req_s mem_req,
  output logic mem_gnt,
  output logic mem_rvalid,
  output logic [31:0] mem_rdata
);
  logic [31:0] ram [0:255]; // descriptors and buffers
  logic [31:0] ptr_ff; // next word to return
  logic [4:0] left_ff; // beats still owed
  logic cyc_ff; // stall phase
  // ----------------------------------------------------------------
  // grant, write and beat return
  // ----------------------------------------------------------------
  // four aligned words per descriptor
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_gnt <= 1'b0;
      mem_rvalid <= 1'b0;
      mem_rdata <= 32'h0;
      ptr_ff <= 32'h0;
      left_ff <= 5'h0;
      cyc_ff <= 1'b0;
    end else begin
      cyc_ff <= ~cyc_ff;
      // one request at a time: no grant while beats are owed
      mem_gnt <= mem_req.valid && !mem_gnt && left_ff == 5'h0 && cyc_ff;
      if (mem_req.valid && mem_gnt) begin
        if (mem_req.we) begin
          ram[mem_req.addr[9:2]] <= mem_req.wdata;
        end else begin
          ptr_ff <= mem_req.addr;
          left_ff <= mem_req.beats;
        end
      end
      mem_rvalid <= left_ff != 5'h0;
      if (left_ff != 5'h0) begin
        mem_rdata <= ram[ptr_ff[9:2]];
        ptr_ff <= ptr_ff + 32'h4;
        left_ff <= left_ff - 5'h1;
      end else begin
        mem_rdata <= ~mem_rdata; // never leave stale data on the bus
      end
    end
  end
endmodule : sys_mem

// ### verification/testbench.sv
// Purpose: self-checking bench for the transmit dma engine
// Assumes: memory model behind the request port, apb master here
// Notes: buffer byte at address a holds a[7:0]
`timescale 1ns/1ps
module testbench;
  import usb_dma_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, mem_rdata, rd;
  logic pready, pslverr, mem_gnt, mem_rvalid, er;
  logic [NUM_CH-1:0] fifo_ready = 4'h0;
  mem_req_s mem_req;
  fifo_beat_s fifo_out;
  int bad_count = 0, samples_checked = 0;
  always #2.5 pclk = ~pclk;
  usb_tx_dma dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .fifo_out(fifo_out), .fifo_ready(fifo_ready));
  sys_mem mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin chk("pready", 1, 0); complete_run(); end
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // collect bytes of one endpoint with ready toggling every cycle
  task automatic rx(input logic [2:0] ep, input logic [7:0] exp[$], input logic z);
    int n, k;
    k = 0;
    for (n = 0; n < 600 && k < exp.size(); n++) begin
      @(posedge pclk);
      if (fifo_out.valid === 1'b1 && fifo_ready[ep-1] === 1'b1) begin
        chk("ep", ep, fifo_out.ep);
        chk("data", exp[k], fifo_out.data);
        chk("last", k == exp.size() - 1, fifo_out.last);
        chk("zlp", z, fifo_out.zlp);
        k++;
      end
      fifo_ready <= (n[0] || k == exp.size()) ? 4'h0 : 4'hf;
    end
    if (k < exp.size()) begin chk("bytes", exp.size(), k); complete_run(); end
  endtask : rx
  // poll status until the engine is idle
  task automatic idle();
    for (int n = 0; n < 100; n++) begin
      apb(1'b0, OFF_STATUS, 32'h0);
      if (rd[15] === 1'b0) break;
    end
    chk("busy", 32'h0, rd & 32'h0000_800f);
    // an engine that never goes idle ends the run here
    if (rd[15] !== 1'b0) complete_run();
  endtask : idle
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic regs();
    apb(1'b0, OFF_MODE, 32'h0); chk("mode rst", {24'h0, MODE_RST}, rd);
    apb(1'b0, 8'hfc, 32'h0); chk("unmapped err", 1, er);
    apb(1'b1, OFF_MODE, 32'h8); apb(1'b0, OFF_MODE, 32'h0); chk("mode", 32'h8, rd);
  endtask : regs
  task automatic one_buffer();
    apb(1'b1, OFF_TX_HEAD + 8'h4, 32'h100);
    rx(3'h2, '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07}, 1'b0);
    idle();
    chk("own qend", 32'hd000_0005, mem.ram[8'h43]);
    // the saved pointer follows the next link, so a finished queue reads zero
    apb(1'b0, OFF_TX_CUR + 8'h4, 32'h0); chk("cur ptr", 32'h0, rd);
  endtask : one_buffer
  task automatic zero_byte();
    apb(1'b1, OFF_TX_HEAD, 32'h140);
    rx(3'h1, '{8'h00}, 1'b1);
    idle();
  endtask : zero_byte
  task automatic truncated();
    apb(1'b1, OFF_TX_HEAD + 8'hc, 32'h180);
    rx(3'h4, '{8'h10, 8'h11, 8'h12, 8'h20}, 1'b0);
    idle();
    chk("start own", 32'h8000_0004, mem.ram[8'h63]);
    chk("end qend", 32'h5000_0000, mem.ram[8'h67]);
  endtask : truncated
  // start descriptor still owned by software: nothing moves, nothing is written back
  task automatic not_owned();
    apb(1'b1, OFF_TX_HEAD + 8'h8, 32'h1c0);
    idle();
    chk("no byte", 32'h0, {31'h0, fifo_out.valid});
    chk("own kept", 32'hc000_0002, mem.ram[8'h73]);
    apb(1'b0, OFF_TX_CUR + 8'h8, 32'h0); chk("cur held", 32'h1c0, rd);
  endtask : not_owned
  initial begin
    for (int i = 8'h80; i < 8'h90; i++) mem.ram[i] = {8'(4*i+3), 8'(4*i+2), 8'(4*i+1), 8'(4*i)};
    // odd buffer start, offset only on start, chains built first
    // every offset stays below its buffer length
    mem.ram[8'h40] = 32'h0; mem.ram[8'h41] = 32'h201; mem.ram[8'h42] = 32'h0002_0005;
    mem.ram[8'h43] = 32'he000_0005;
    mem.ram[8'h50] = 32'h0; mem.ram[8'h51] = 32'h200; mem.ram[8'h52] = 32'h4;
    mem.ram[8'h53] = 32'he080_0000;
    mem.ram[8'h60] = 32'h190; mem.ram[8'h61] = 32'h210; mem.ram[8'h62] = 32'h3;
    mem.ram[8'h63] = 32'ha000_0004;
    mem.ram[8'h64] = 32'h0; mem.ram[8'h65] = 32'h220; mem.ram[8'h66] = 32'h3;
    mem.ram[8'h67] = 32'h4000_0000;
    mem.ram[8'h70] = 32'h0; mem.ram[8'h71] = 32'h200; mem.ram[8'h72] = 32'h2;
    mem.ram[8'h73] = 32'hc000_0002;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    regs();
    one_buffer();
    zero_byte();
    truncated();
    not_owned();
    complete_run();
  end
endmodule : testbench
